// file: verilog/clic_loopback_irq_ctrl.sv
// Per-channel loopback control, automatic loopback on in-band codes,
// interrupt edge select, interrupt flags and masks, behind AXI4-Lite.
// Assumes status inputs come from detectors on the same clock.
//
// The AXI4-Lite register port was decided locally.
module clic_loopback_irq_ctrl
  import clic_pkg::*;
#(
  parameter int NCH      = MAX_CH,
  parameter int CNT_W    = 30,
  parameter int AUTO_CYC = AUTO_PERSIST_CYC,
  parameter int T1_CYC   = T1_PERSIST_CYC,
  parameter int E1_CYC   = E1_PERSIST_CYC
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic                  e1_mode,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [ADDR_W-1:0]     araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire clic_chan_in_t [NCH-1:0]  chan_in,
  output clic_chan_out_t [NCH-1:0]      chan_out,
  output logic                       irq
);

  typedef struct packed {
    clic_chan_state_t [NCH-1:0] ch;
    logic [ADDR_W-1:0]          aw_addr;
    logic                       aw_full;
    logic [7:0]                 w_byte;
    logic                       w_en;
    logic                       w_full;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } clic_top_st_t;

  localparam clic_top_st_t TOP_RST = '{ch: {NCH{CH_RST}}, default: '0};

  if (NCH < 1 || NCH > MAX_CH) begin : g_chk_nch
    $error("clic_loopback_irq_ctrl: NCH out of range");
  end
  if (CNT_W < 2 || CNT_W > 31 || AUTO_CYC < 1 || T1_CYC < 1 ||
      E1_CYC < 1 || AUTO_CYC >= (1 << CNT_W) ||
      T1_CYC >= (1 << CNT_W) || E1_CYC >= (1 << CNT_W)) begin : g_chk_cyc
    $error("clic_loopback_irq_ctrl: persistence counts do not fit");
  end

  clic_top_st_t r;
  clic_top_st_t n;
  clic_dec_t    wr_dec;
  clic_dec_t    rd_dec;

  logic [NCH-1:0] hit_at;
  logic [NCH-1:0] hit_ar;
  logic [NCH-1:0] hit_dt;
  logic [NCH-1:0] hit_dr;

  // Channel number in index bits 9:6, register in 5:0
  function automatic clic_dec_t decode(input logic [ADDR_W-1:0] a);
    clic_dec_t d;
    d = '0;
    d.ch = a[ADDR_W-1:CH_SHIFT+2];
    case (a[CH_SHIFT+1:2])
      IDX_LOOP:  d.sel = REG_LOOP;
      IDX_EDGE:  d.sel = REG_EDGE;
      IDX_MASK1: d.sel = REG_MASK1;
      IDX_MASK2: d.sel = REG_MASK2;
      IDX_STAT1: d.sel = REG_STAT1;
      IDX_STAT2: d.sel = REG_STAT2;
      IDX_FLAG1: d.sel = REG_FLAG1;
      IDX_FLAG2: d.sel = REG_FLAG2;
      default:   d.sel = REG_NONE;
    endcase
    d.ok = (d.sel != REG_NONE) && (int'(d.ch) < NCH);
    return d;
  endfunction

  assign wr_dec = decode(r.aw_addr);
  assign rd_dec = decode(araddr);

  // Code persistence timers, long threshold while auto loopback is on
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [CNT_W-1:0] thr;
    assign thr = r.ch[c].loop_ctl[LP_AUTO] ? CNT_W'(AUTO_CYC) :
                 (e1_mode ? CNT_W'(E1_CYC) : CNT_W'(T1_CYC));
    clic_persist #(.CNT_W(CNT_W)) u_act_tx (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .detect(chan_in[c].activate_code_tx), .thresh(thr),
      .hit(hit_at[c]));
    clic_persist #(.CNT_W(CNT_W)) u_act_rx (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .detect(chan_in[c].activate_code_rx), .thresh(thr),
      .hit(hit_ar[c]));
    clic_persist #(.CNT_W(CNT_W)) u_deact_tx (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .detect(chan_in[c].deactivate_code_tx), .thresh(thr),
      .hit(hit_dt[c]));
    clic_persist #(.CNT_W(CNT_W)) u_deact_rx (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .detect(chan_in[c].deactivate_code_rx), .thresh(thr),
      .hit(hit_dr[c]));
  end

  assign awready = ce && !r.aw_full && !r.bvalid;
  assign wready  = ce && !r.w_full && !r.bvalid;
  assign arready = ce && !r.rvalid;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;

  logic [NCH-1:0][7:0] lv1_a;
  logic [NCH-1:0][7:0] lv2_a;
  logic [7:0] lvl1;
  logic [7:0] lvl2;
  logic [7:0] any1;
  logic [7:0] any2;
  logic [7:0] ev1;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] es;
  logic [7:0] rbyte;
  logic       do_wr;
  logic       sel_c;
  logic       auto_en;
  logic [3:0] rch;

  always_comb begin
    n = r;
    lv1_a = '0;
    lv2_a = '0;
    lvl1 = '0;
    lvl2 = '0;
    any1 = '0;
    any2 = '0;
    ev1 = '0;
    set1 = '0;
    set2 = '0;
    clr1 = '0;
    clr2 = '0;
    es = '0;
    rbyte = '0;
    sel_c = 1'b0;
    auto_en = 1'b0;
    rch = '0;
    do_wr = 1'b0;

    // Write address and data may arrive in either order
    if (awvalid && awready) begin
      n.aw_addr = awaddr;
      n.aw_full = 1'b1;
    end
    if (wvalid && wready) begin
      n.w_byte = wdata[7:0];
      n.w_en   = wstrb[0];
      n.w_full = 1'b1;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_full && r.w_full && !r.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_dec.ok ? RESP_OKAY : RESP_SLVERR;
      do_wr     = wr_dec.ok && r.w_en;
    end

    for (int c = 0; c < NCH; c++) begin
      sel_c = do_wr && (int'(wr_dec.ch) == c);
      es = r.ch[c].edge_sel;
      auto_en = r.ch[c].loop_ctl[LP_AUTO];

      lvl1 = '0;
      lvl1[G1_OC]   = chan_in[c].overcurrent_state;
      lvl1[G1_TCK]  = chan_in[c].tx_clock_missing_state;
      lvl1[G1_TLOS] = chan_in[c].tx_signal_loss_state;
      lvl1[G1_SLOS] = chan_in[c].system_signal_loss_state;
      lvl1[G1_LLOS] = chan_in[c].line_signal_loss_state;
      lvl2 = '0;
      lvl2[G2_SAIS] = chan_in[c].system_alarm_indication_state;
      lvl2[G2_LAIS] = chan_in[c].line_alarm_indication_state;
      lvl2[G2_PA]   = chan_in[c].pattern_sync_state;
      lvl2[G2_IBA]  = hit_at[c] || hit_ar[c];
      lvl2[G2_IBD]  = hit_dt[c] || hit_dr[c];
      lv1_a[c] = lvl1;
      lv2_a[c] = lvl2;

      // Which sources also flag a falling edge
      any1 = '0;
      any1[G1_OC]   = es[ES_OC];
      any1[G1_TCK]  = es[ES_TCK];
      any1[G1_TLOS] = es[ES_TLOS];
      any1[G1_SLOS] = es[ES_LOS];
      any1[G1_LLOS] = es[ES_LOS];
      any2 = '0;
      any2[G2_SAIS] = es[ES_AIS];
      any2[G2_LAIS] = es[ES_AIS];
      any2[G2_PA]   = es[ES_PA];
      any2[G2_IBA]  = es[ES_IB];
      any2[G2_IBD]  = es[ES_IB];

      ev1 = '0;
      ev1[G1_AMP] = chan_in[c].amplitude_overflow;
      ev1[G1_TJ]  = chan_in[c].tx_jitter_fifo_error;
      ev1[G1_RJ]  = chan_in[c].rx_jitter_fifo_error;

      set1 = ev1 | (lvl1 & ~r.ch[c].prev1) |
             (any1 & ~lvl1 & r.ch[c].prev1);
      set2 = (lvl2 & ~r.ch[c].prev2) | (any2 & ~lvl2 & r.ch[c].prev2);
      clr1 = (sel_c && wr_dec.sel == REG_FLAG1) ? r.w_byte : '0;
      clr2 = (sel_c && wr_dec.sel == REG_FLAG2) ? r.w_byte : '0;
      n.ch[c].flag1 = (r.ch[c].flag1 & ~clr1) | set1;
      n.ch[c].flag2 = (r.ch[c].flag2 & ~clr2) | set2;
      n.ch[c].prev1 = lvl1;
      n.ch[c].prev2 = lvl2;

      if (sel_c) begin
        case (wr_dec.sel)
          REG_LOOP:  n.ch[c].loop_ctl = r.w_byte & LOOP_WMASK;
          REG_EDGE:  n.ch[c].edge_sel = r.w_byte & EDGE_WMASK;
          REG_MASK1: n.ch[c].mask1 = r.w_byte;
          REG_MASK2: n.ch[c].mask2 = r.w_byte & MASK2_RST;
          default:   ;
        endcase
      end

      // Automatic loopback follows sustained in-band codes
      if (!auto_en) begin
        n.ch[c].auto_dig = 1'b0;
        n.ch[c].auto_rem = 1'b0;
      end else begin
        if (hit_dt[c]) begin
          n.ch[c].auto_dig = 1'b0;
        end else if (hit_at[c]) begin
          n.ch[c].auto_dig = 1'b1;
        end
        if (hit_dr[c]) begin
          n.ch[c].auto_rem = 1'b0;
        end else if (hit_ar[c]) begin
          n.ch[c].auto_rem = 1'b1;
        end
      end
    end

    // Read answer one cycle after the address is taken
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      rch = rd_dec.ok ? rd_dec.ch : 4'h0;
      case (rd_dec.sel)
        REG_LOOP:  rbyte = r.ch[rch].loop_ctl;
        REG_EDGE:  rbyte = r.ch[rch].edge_sel;
        REG_MASK1: rbyte = r.ch[rch].mask1;
        REG_MASK2: rbyte = r.ch[rch].mask2;
        REG_STAT1: begin
          rbyte = lv1_a[rch];
          rbyte[STAT1_AUTO] = r.ch[rch].auto_dig || r.ch[rch].auto_rem;
        end
        REG_STAT2: rbyte = lv2_a[rch];
        REG_FLAG1: rbyte = r.ch[rch].flag1;
        REG_FLAG2: rbyte = r.ch[rch].flag2;
        default:   rbyte = '0;
      endcase
      if (!rd_dec.ok) begin
        rbyte = '0;
      end
      n.rvalid = 1'b1;
      n.rdata  = {24'h000000, rbyte};
      n.rresp  = rd_dec.ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= TOP_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  logic irq_c;

  always_comb begin
    irq_c = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      chan_out[c].digital_loop_active =
        r.ch[c].loop_ctl[LP_DIG] || r.ch[c].auto_dig;
      chan_out[c].remote_loop_active =
        r.ch[c].loop_ctl[LP_REM] || r.ch[c].auto_rem;
      chan_out[c].analog_loop_active = r.ch[c].loop_ctl[LP_ANA];
      chan_out[c].auto_loop_active = r.ch[c].auto_dig || r.ch[c].auto_rem;
      chan_out[c].activate_code_state = hit_at[c] || hit_ar[c];
      chan_out[c].deactivate_code_state = hit_dt[c] || hit_dr[c];
      // Mask bits 7..0 gate sources of the same position
      irq_c = irq_c || |(r.ch[c].flag1 & ~r.ch[c].mask1) ||
              |(r.ch[c].flag2 & ~r.ch[c].mask2);
    end
  end

  assign irq = irq_c;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_auto_enter;
    $rose(r.ch[0].auto_dig) |->
      $past(hit_at[0]) && $past(r.ch[0].loop_ctl[LP_AUTO]);
  endproperty
  a_auto_enter: assert property (p_auto_enter)
    else $error("auto digital loop entered without activate code");

  property p_auto_exit;
    ce && r.ch[0].auto_dig && hit_dt[0] |=> !r.ch[0].auto_dig;
  endproperty
  a_auto_exit: assert property (p_auto_exit)
    else $error("auto digital loop kept after deactivate code");

  property p_auto_off;
    ce && !r.ch[0].loop_ctl[LP_AUTO] |=>
      !r.ch[0].auto_dig && !r.ch[0].auto_rem;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("auto loop active while disabled");

  property p_digital;
    !r.ch[0].auto_dig |->
      chan_out[0].digital_loop_active == r.ch[0].loop_ctl[LP_DIG];
  endproperty
  a_digital: assert property (p_digital)
    else $error("digital loop output differs from control bit");

  property p_rise_sets;
    ce && !r.ch[0].prev2[G2_PA] && chan_in[0].pattern_sync_state |=>
      r.ch[0].flag2[G2_PA];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising pattern sync did not set its flag");

  property p_fall_ignored;
    ce && r.ch[0].prev1[G1_OC] && !chan_in[0].overcurrent_state &&
      !r.ch[0].edge_sel[ES_OC] && !r.ch[0].flag1[G1_OC] |=>
      !r.ch[0].flag1[G1_OC];
  endproperty
  a_fall_ignored: assert property (p_fall_ignored)
    else $error("falling overcurrent set flag in rising-only mode");

  property p_mask_reset;
    $rose(aresetn) |-> r.ch[0].mask1 == MASK_RST && !irq;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("first mask not all ones after reset");

  property p_w1c;
    ce && r.aw_full && r.w_full && !r.bvalid && r.w_en &&
      wr_dec.sel == REG_FLAG1 && wr_dec.ch == 4'h0 &&
      r.w_byte[G1_LLOS] &&
      chan_in[0].line_signal_loss_state == r.ch[0].prev1[G1_LLOS] |=>
      !r.ch[0].flag1[G1_LLOS];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear line loss flag");

  property p_irq;
    ce && chan_in[0].line_signal_loss_state &&
      !r.ch[0].prev1[G1_LLOS] && !r.ch[0].mask1[G1_LLOS] |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked flag did not raise interrupt");

endmodule

// file: verilog/clic_pkg.sv
// Shared constants, register layout and carrier types of the per-channel
// loopback and interrupt control block.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port.
package clic_pkg;

  localparam int ADDR_W = 12;
  localparam int MAX_CH = 16;

  // Register indices inside a channel; channel number sits above them
  localparam int         CH_SHIFT  = 6;
  localparam logic [5:0] IDX_LOOP  = 6'h19;
  localparam logic [5:0] IDX_EDGE  = 6'h1a;
  localparam logic [5:0] IDX_MASK1 = 6'h1b;
  localparam logic [5:0] IDX_MASK2 = 6'h1c;
  localparam logic [5:0] IDX_STAT1 = 6'h1e;
  localparam logic [5:0] IDX_STAT2 = 6'h1f;
  localparam logic [5:0] IDX_FLAG1 = 6'h20;
  localparam logic [5:0] IDX_FLAG2 = 6'h21;

  // Loopback control fields
  localparam int LP_AUTO = 3;
  localparam int LP_DIG  = 2;
  localparam int LP_REM  = 1;
  localparam int LP_ANA  = 0;

  // Edge select fields
  localparam int ES_AIS  = 6;
  localparam int ES_PA   = 5;
  localparam int ES_OC   = 4;
  localparam int ES_TCK  = 3;
  localparam int ES_TLOS = 2;
  localparam int ES_LOS  = 1;
  localparam int ES_IB   = 0;

  // First source group: flag, mask and status positions
  localparam int G1_AMP  = 7;
  localparam int G1_TJ   = 6;
  localparam int G1_RJ   = 5;
  localparam int G1_OC   = 4;
  localparam int G1_TCK  = 3;
  localparam int G1_TLOS = 2;
  localparam int G1_SLOS = 1;
  localparam int G1_LLOS = 0;
  localparam int STAT1_AUTO = 7;

  // Second source group
  localparam int G2_SAIS = 7;
  localparam int G2_LAIS = 6;
  localparam int G2_PA   = 5;
  localparam int G2_IBA  = 1;
  localparam int G2_IBD  = 0;

  // Reset values and writable bits
  localparam logic [7:0] LOOP_RST   = 8'h00;
  localparam logic [7:0] EDGE_RST   = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'hff;
  localparam logic [7:0] MASK2_RST  = 8'he3;
  localparam logic [7:0] LOOP_WMASK = 8'h0f;
  localparam logic [7:0] EDGE_WMASK = 8'h7f;

  // Persistence times and their cycle counts
  localparam int CLK_KHZ         = 125000;
  localparam int AUTO_PERSIST_MS = 5100;
  localparam int T1_PERSIST_MS   = 40;
  localparam int E1_PERSIST_MS   = 30;
  localparam int AUTO_PERSIST_CYC = AUTO_PERSIST_MS * CLK_KHZ;
  localparam int T1_PERSIST_CYC   = T1_PERSIST_MS * CLK_KHZ;
  localparam int E1_PERSIST_CYC   = E1_PERSIST_MS * CLK_KHZ;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    REG_NONE, REG_LOOP, REG_EDGE, REG_MASK1, REG_MASK2,
    REG_STAT1, REG_STAT2, REG_FLAG1, REG_FLAG2
  } clic_reg_e;

  typedef struct packed {
    logic      ok;
    logic [3:0] ch;
    clic_reg_e sel;
  } clic_dec_t;

  typedef struct packed {
    logic amplitude_overflow;
    logic tx_jitter_fifo_error;
    logic rx_jitter_fifo_error;
    logic overcurrent_state;
    logic tx_clock_missing_state;
    logic tx_signal_loss_state;
    logic system_signal_loss_state;
    logic line_signal_loss_state;
    logic system_alarm_indication_state;
    logic line_alarm_indication_state;
    logic pattern_sync_state;
    logic activate_code_tx;
    logic activate_code_rx;
    logic deactivate_code_tx;
    logic deactivate_code_rx;
  } clic_chan_in_t;

  typedef struct packed {
    logic digital_loop_active;
    logic remote_loop_active;
    logic analog_loop_active;
    logic auto_loop_active;
    logic activate_code_state;
    logic deactivate_code_state;
  } clic_chan_out_t;

  typedef struct packed {
    logic [7:0] loop_ctl;
    logic [7:0] edge_sel;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] flag1;
    logic [7:0] flag2;
    logic [7:0] prev1;
    logic [7:0] prev2;
    logic       auto_dig;
    logic       auto_rem;
  } clic_chan_state_t;

  localparam clic_chan_state_t CH_RST = '{
    loop_ctl: LOOP_RST, edge_sel: EDGE_RST, mask1: MASK_RST,
    mask2: MASK2_RST, default: '0};

endpackage

// file: verilog/clic_persist.sv
// Persistence timer: flags a level that has stayed high for more than
// a programmable number of cycles.
// Assumes detect comes from logic on the same clock.
module clic_persist
  import clic_pkg::*;
#(
  parameter int CNT_W = 30
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             detect,
  input  wire logic [CNT_W-1:0] thresh,
  output logic                  hit
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } clic_persist_st_t;

  clic_persist_st_t r;
  clic_persist_st_t n;

  if (CNT_W < 2 || CNT_W > 31) begin : g_chk
    $error("clic_persist: CNT_W out of range");
  end

  // Counts detect cycles seen before this one, saturating at thresh
  always_comb begin
    n = r;
    if (!detect) begin
      n.cnt = '0;
    end else if (r.cnt < thresh) begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hit = detect && (r.cnt >= thresh);

endmodule

// file: bench/clic_loopback_irq_ctrl_tb.sv
// Self-checking bench for the loopback and interrupt control block.
// Drives the register port and channel inputs itself; 125 MHz clock.
module clic_loopback_irq_ctrl_tb
  import clic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic                  aclk = 0;
  logic                  aresetn = 0;
  logic                  awvalid = 0;
  logic                  wvalid = 0;
  logic                  bready = 0;
  logic                  arvalid = 0;
  logic                  rready = 0;
  logic                  ce = 1;
  logic                  e1_mode = 0;
  logic [11:0]           awaddr = '0;
  logic [11:0]           araddr = '0;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = '0;
  logic                  awready;
  logic                  wready;
  logic                  bvalid;
  logic                  arready;
  logic                  rvalid;
  logic                  irq;
  logic [1:0]            bresp;
  logic [1:0]            rresp;
  logic [31:0]           rdata;
  clic_chan_in_t [15:0]  ci = '0;
  clic_chan_out_t [15:0] co;
  int                    miscompares = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  int                    ib[8] = '{11, 10, 9, 8, 7, 6, 5, 4};
  int                    eb[8] = '{4, 3, 2, 1, 1, 6, 6, 5};
  int                    fb[8] = '{4, 3, 2, 1, 0, 7, 6, 5};

  always #4 aclk = ~aclk;

  clic_loopback_irq_ctrl #(
    .NCH(16), .CNT_W(30), .AUTO_CYC(40), .T1_CYC(8), .E1_CYC(6)
  ) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .e1_mode(e1_mode),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .chan_in(ci), .chan_out(co), .irq(irq)
  );

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      print_verdict;
    end
  end

  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask

  task w8(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One register write; byte address is four times the register index
  task wr(input logic [3:0] c, input logic [5:0] x, input logic [7:0] d,
          input logic [1:0] er = RESP_OKAY);
    logic ad;
    logic wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= {c, x, 2'b00};
    awvalid <= 1;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    ck("bresp", 32'(er), 32'(bresp));
  endtask

  task rd(input logic [3:0] c, input logic [5:0] x, input logic [7:0] e,
          input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= {c, x, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    ck("rdata", {24'h0, e}, rdata);
    ck("rresp", 32'(er), 32'(rresp));
  endtask

  // Flag set, masked, unmasked, cleared by writing one
  task fl(input logic g, input int b);
    logic [7:0] v;
    v = 8'h01 << b;
    rd(0, IDX_FLAG1 + g, v);
    ck("irq masked", 0, 32'(irq));
    wr(0, IDX_MASK1 + g, ~v);
    w8(2);
    ck("irq open", 1, 32'(irq));
    wr(0, IDX_MASK1 + g, 8'hff);
    wr(0, IDX_FLAG1 + g, v);
    rd(0, IDX_FLAG1 + g, 8'h00);
  endtask

  initial begin
    w8(16);
    aresetn <= 1;
    rd(0, IDX_LOOP, 8'h00);
    rd(0, IDX_EDGE, 8'h00);
    rd(0, IDX_MASK1, 8'hff);
    rd(15, IDX_MASK1, 8'hff);
    wr(0, IDX_LOOP, 8'hff);
    rd(0, IDX_LOOP, 8'h0f);
    ck("loops on", 3'b111, 32'(co[0][5:3]));
    wr(8, IDX_LOOP, 8'h02);
    w8(2);
    ck("ch8 loops", 3'b010, 32'(co[8][5:3]));
    wr(0, IDX_LOOP, 8'h00);
    w8(2);
    ck("loops off", 0, 32'(co[0][5:3]));
    wr(0, IDX_EDGE, 8'hff);
    rd(0, IDX_EDGE, 8'h7f);
    wr(0, 6'h3f, 8'h00, RESP_SLVERR);
    rd(0, 6'h00, 8'h00, RESP_SLVERR);
    // Level sources: rising only, then both edges
    for (int i = 0; i < 8; i++) begin
      wr(0, IDX_EDGE, 8'h00);
      @(posedge aclk);
      ci[0][ib[i]] <= 1;
      fl(i > 4, fb[i]);
      @(posedge aclk);
      ci[0][ib[i]] <= 0;
      rd(0, IDX_FLAG1 + (i > 4), 8'h00);
      wr(0, IDX_EDGE, 8'h01 << eb[i]);
      @(posedge aclk);
      ci[0][ib[i]] <= 1;
      w8(3);
      wr(0, IDX_FLAG1 + (i > 4), 8'hff);
      @(posedge aclk);
      ci[0][ib[i]] <= 0;
      fl(i > 4, fb[i]);
    end
    // Event sources
    for (int b = 5; b < 8; b++) begin
      @(posedge aclk);
      ci[0][b + 7] <= 1;
      @(posedge aclk);
      ci[0][b + 7] <= 0;
      fl(0, b);
    end
    // Short code threshold without auto loopback
    wr(0, IDX_EDGE, 8'h00);
    @(posedge aclk);
    ci[0][3] <= 1;
    w8(5);
    ck("act early", 0, 32'(co[0][1]));
    w8(6);
    ck("act short", 1, 32'(co[0][1]));
    rd(0, IDX_STAT2, 8'h02);
    ck("dig manual", 0, 32'(co[0][5]));
    fl(1, 1);
    wr(0, IDX_EDGE, 8'h01);
    @(posedge aclk);
    ci[0][3] <= 0;
    fl(1, 1);
    // Automatic loopback on the transmit path
    wr(0, IDX_LOOP, 8'h08);
    @(posedge aclk);
    ci[0][3] <= 1;
    w8(30);
    ck("dig early", 0, 32'(co[0][5]));
    ck("act long", 0, 32'(co[0][1]));
    w8(20);
    ck("dig auto", 1, 32'(co[0][5]));
    ck("auto state", 1, 32'(co[0][2]));
    @(posedge aclk);
    ci[0][3] <= 0;
    ci[0][1] <= 1;
    w8(30);
    ck("dig held", 1, 32'(co[0][5]));
    w8(20);
    ck("dig left", 0, 32'(co[0][5]));
    // Receive path, then auto enable cleared
    @(posedge aclk);
    ci[0][1] <= 0;
    ci[0][2] <= 1;
    w8(50);
    ck("rem auto", 1, 32'(co[0][4]));
    rd(0, IDX_STAT1, 8'h80);
    wr(0, IDX_LOOP, 8'h00);
    w8(2);
    ck("rem off", 0, 32'(co[0][4]));
    // Short threshold in E1 mode
    @(posedge aclk);
    ci[0][2] <= 0;
    e1_mode <= 1;
    @(posedge aclk);
    ci[0][0] <= 1;
    w8(6);
    ck("deact e1 early", 0, 32'(co[0][0]));
    w8(2);
    ck("deact e1", 1, 32'(co[0][0]));
    // Clock enable low freezes timers and refuses the bus
    @(posedge aclk);
    ci[0][0] <= 0;
    ce <= 0;
    @(posedge aclk);
    ci[0][3] <= 1;
    w8(10);
    ck("ready frozen", 0, 32'({awready, wready, arready}));
    ck("act frozen", 0, 32'(co[0][1]));
    ce <= 1;
    w8(8);
    ck("act resumed", 1, 32'(co[0][1]));
    print_verdict;
  end
endmodule
